//--- hdl/gpb_pkg.sv
package gpb_pkg;
  localparam int GPB_NPINS = 4;
  localparam int GPB_CLK_HZ = 20000000;
  localparam int GPB_PWM_HZ = 500;
  localparam int GPB_DUTY_STEPS = 100;
  localparam int GPB_PWM_TICK_CYC = GPB_CLK_HZ / (GPB_PWM_HZ * GPB_DUTY_STEPS);
  localparam int GPB_BLINK_MS = 100;
  localparam int GPB_BLINK_CYC = (GPB_CLK_HZ / 1000) * GPB_BLINK_MS;
  localparam int GPB_PATTERN_W = 32;
  localparam logic [7:0] GPB_PORT_IDX = 8'h00;
  localparam logic [7:0] GPB_MAX_PIN = 8'h03;
  localparam logic [7:0] GPB_FULL_DUTY = 8'h64;
  localparam logic [7:0] GPB_RST_DUTY = 8'h00;
  localparam logic [31:0] GPB_RST_PATTERN = 32'hFFFFFFFF;
  localparam logic GPB_RST_POLARITY = 1'b1;

  typedef enum logic [2:0] {
    GPB_CMD_NONE,
    GPB_CMD_WRITE_PORT,
    GPB_CMD_WRITE_PIN,
    GPB_CMD_POLARITY,
    GPB_CMD_DUTY,
    GPB_CMD_BLINK
  } gpb_cmd_t;

  typedef struct packed {
    gpb_cmd_t op;
    logic [7:0] port_idx;
    logic [7:0] pin_idx;
    logic [31:0] value;
  } gpb_req_t;
endpackage

//--- hdl/gpb_tick.sv
`timescale 1ns/100ps
module gpb_tick import gpb_pkg::*; #(
  parameter int PERIOD = 10
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // One-cycle pulse every PERIOD cycles
  output logic tick
);
  logic [31:0] cnt_ff;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= 32'h00000000;
      tick <= 1'b0;
    end else if (cnt_ff == 32'(PERIOD - 1)) begin
      cnt_ff <= 32'h00000000;
      tick <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 32'h00000001;
      tick <= 1'b0;
    end
  end
endmodule // gpb_tick

//--- hdl/gpb_pwm_core.sv
`timescale 1ns/100ps
module gpb_pwm_core import gpb_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Step pulse, one per duty slot
  input wire logic step,
  // Current slot of the 100-slot frame
  output logic [7:0] phase
);
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      phase <= 8'h00;
    end else if (step) begin
      phase <= (phase == GPB_FULL_DUTY - 8'h01) ? 8'h00 : phase + 8'h01;
    end
  end
endmodule // gpb_pwm_core

//--- hdl/gpb_port.sv
`timescale 1ns/100ps
// What this block does
// - Four output pins, indexed 0 to 3, form one output port.
// - Port write updates all four pins at once from the value.
// - Value 15 makes all pins active, 0 all inactive; bit i drives pin i.
// - Pin write changes only the addressed pin.
// - Per-pin polarity: level 0 active low, level 1 active high.
// - Every pin's polarity is active high after reset.
// - Outputs are low from reset and always driven afterwards.
// - Duty command sets one pin's modulator duty in percent.
// - Modulator runs at a fixed 500 Hz whatever the duty.
// - Modulator has 100 duty steps from off to fully on.
// - Duty 100 holds the pin continuously active.
// - Blink command loads a 32-bit mask, one bit per 100 ms slot.
// - Mask LSB gates the pin; mask rotates one bit every 100 ms.
// - Duty and blink may act together on one pin.
module gpb_port import gpb_pkg::*; #(
  parameter int NPINS = GPB_NPINS,
  parameter int BLINK_CYC = GPB_BLINK_CYC,
  parameter int PWM_TICK_CYC = GPB_PWM_TICK_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Host control command, one-cycle valid
  input wire logic cmd_valid,
  input wire gpb_req_t cmd,
  // Output pins
  output logic out_pin_zero,
  output logic out_pin_one,
  output logic out_pin_two,
  output logic out_pin_three,
  // Command status
  output logic cmd_reject_ff
);
  logic [NPINS-1:0] level_ff;
  logic [NPINS-1:0] polarity_ff;
  logic [7:0] duty_ff [NPINS];
  logic [31:0] pattern_ff [NPINS];
  logic [NPINS-1:0] pin_ff;
  logic [NPINS-1:0] nxt_pin;
  logic pwm_step;
  logic blink_step;
  logic [7:0] phase;
  logic addr_ok;
  logic port_ok;

  function automatic logic [1:0] pin_of(input logic [7:0] idx);
    return idx[1:0];
  endfunction

  gpb_tick #(.PERIOD(PWM_TICK_CYC)) u_pwm_tick (
    .mclk(mclk),
    .resetn(resetn),
    .tick(pwm_step)
  );

  gpb_tick #(.PERIOD(BLINK_CYC)) u_blink_tick (
    .mclk(mclk),
    .resetn(resetn),
    .tick(blink_step)
  );

  // 100 slots of 20 us each give a 2 ms frame
  gpb_pwm_core u_pwm (
    .mclk(mclk),
    .resetn(resetn),
    .step(pwm_step),
    .phase(phase)
  );

  assign port_ok = cmd.port_idx == GPB_PORT_IDX;
  assign addr_ok = port_ok && cmd.pin_idx <= GPB_MAX_PIN;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cmd_reject_ff <= 1'b0;
    end else if (cmd_valid) begin
      cmd_reject_ff <= (cmd.op == GPB_CMD_WRITE_PORT) ? !port_ok : !addr_ok;
    end
  end

  // Direct levels
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      level_ff <= '0;
    end else if (cmd_valid && cmd.op == GPB_CMD_WRITE_PORT && port_ok) begin
      level_ff <= cmd.value[NPINS-1:0];
    end else if (cmd_valid && cmd.op == GPB_CMD_WRITE_PIN && addr_ok) begin
      level_ff[pin_of(cmd.pin_idx)] <= cmd.value[0];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      polarity_ff <= {NPINS{GPB_RST_POLARITY}};
    end else if (cmd_valid && cmd.op == GPB_CMD_POLARITY && addr_ok) begin
      polarity_ff[pin_of(cmd.pin_idx)] <= cmd.value[0];
    end
  end

  // Duty above 100 is clamped to fully on
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NPINS; i++) begin
        duty_ff[i] <= GPB_RST_DUTY;
      end
    end else if (cmd_valid && cmd.op == GPB_CMD_DUTY && addr_ok) begin
      duty_ff[pin_of(cmd.pin_idx)] <= (cmd.value[31:0] > 32'(GPB_FULL_DUTY)) ?
        GPB_FULL_DUTY : cmd.value[7:0];
    end
  end

  // A new mask loads unrotated, so its LSB shows at once
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NPINS; i++) begin
        pattern_ff[i] <= GPB_RST_PATTERN;
      end
    end else begin
      for (int i = 0; i < NPINS; i++) begin
        if (cmd_valid && cmd.op == GPB_CMD_BLINK && addr_ok && pin_of(cmd.pin_idx) == 2'(i)) begin
          pattern_ff[i] <= cmd.value;
        end else if (blink_step) begin
          pattern_ff[i] <= {pattern_ff[i][0], pattern_ff[i][31:1]};
        end
      end
    end
  end

  // Nonzero duty replaces the direct level, then blink gates the result, then polarity
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      nxt_pin[i] = level_ff[i];
      if (duty_ff[i] != GPB_RST_DUTY) begin
        // Duty acts as the active source; 100 stays on for every slot
        nxt_pin[i] = (duty_ff[i] >= GPB_FULL_DUTY) || (phase < duty_ff[i]);
      end
      nxt_pin[i] = nxt_pin[i] && pattern_ff[i][0];
      nxt_pin[i] = polarity_ff[i] ? nxt_pin[i] : !nxt_pin[i];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pin_ff <= '0;
    end else begin
      pin_ff <= nxt_pin;
    end
  end

  // Pins come straight from flip-flops, always driven
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      out_pin_zero <= 1'b0;
      out_pin_one <= 1'b0;
      out_pin_two <= 1'b0;
      out_pin_three <= 1'b0;
    end else begin
      out_pin_zero <= pin_ff[0];
      out_pin_one <= pin_ff[1];
      out_pin_two <= pin_ff[2];
      out_pin_three <= pin_ff[3];
    end
  end
endmodule // gpb_port

//--- tb/gpb_port_asserts.sv
`timescale 1ns/100ps
module gpb_port_asserts import gpb_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Command
  input wire logic cmd_valid,
  input wire gpb_req_t cmd,
  // Pins and status
  input wire logic out_pin_zero,
  input wire logic out_pin_one,
  input wire logic out_pin_two,
  input wire logic out_pin_three,
  input wire logic cmd_reject_ff
);
  logic fancy_ff;
  logic ok;
  logic [3:0] p;
  assign p = {out_pin_three, out_pin_two, out_pin_one, out_pin_zero};
  assign ok = cmd_valid && cmd.port_idx == GPB_PORT_IDX && cmd.pin_idx <= GPB_MAX_PIN;
  // Level checks are only exact before any mode command
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) fancy_ff <= 1'b0;
    else if (cmd_valid && cmd.op inside {GPB_CMD_POLARITY, GPB_CMD_DUTY, GPB_CMD_BLINK}) begin
      fancy_ff <= 1'b1;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_reject_bad: assert property (cmd_valid && cmd.port_idx != GPB_PORT_IDX |=> cmd_reject_ff)
    else $error("bad port not flagged");
  a_reject_good: assert property (ok |=> !cmd_reject_ff)
    else $error("good command flagged");
  a_reject_hold: assert property (!cmd_valid |=> $stable(cmd_reject_ff))
    else $error("reject flag moved");
  a_port_value: assert property (!fancy_ff && ok && cmd.op == GPB_CMD_WRITE_PORT
    |-> ##3 p == $past(cmd.value[3:0], 3)) else $error("port write wrong");
  a_pin_only: assert property (!fancy_ff && ok && cmd.op == GPB_CMD_WRITE_PIN && cmd.pin_idx == 8'h02
    |-> ##3 out_pin_two == $past(cmd.value[0], 3) && {p[3], p[1:0]} == $past({p[3], p[1:0]}, 3))
    else $error("pin write wrong");
  a_reset_low: assert property ($rose(resetn) |-> p == 4'h0)
    else $error("pins not low from reset");
  a_dead_cmd: assert property (!fancy_ff && cmd_valid && cmd.port_idx != GPB_PORT_IDX
    |=> $stable(p)[*4]) else $error("ignored command moved pins");
  a_idle_still: assert property ((!cmd_valid && !fancy_ff)[*4] |=> $stable(p))
    else $error("pins moved while idle");
  c_duty: cover property (cmd_valid && cmd.op == GPB_CMD_DUTY);
  c_blink: cover property (cmd_valid && cmd.op == GPB_CMD_BLINK);
  c_reject: cover property (cmd_reject_ff);
endmodule // gpb_port_asserts

//--- tb/gpb_led_load.sv
`timescale 1ns/100ps
module gpb_led_load (
  // Clock
  input wire logic mclk,
  // Loads and count window
  input wire logic [3:0] pins,
  input wire logic count_en,
  output logic [15:0] on_cnt_ff [4]
);
  // Counts lit cycles per pin; cleared whenever the window is closed
  always_ff @(posedge mclk) begin
    for (int i = 0; i < 4; i++) begin
      if (!count_en) on_cnt_ff[i] <= 16'h0000;
      else if (pins[i]) on_cnt_ff[i] <= on_cnt_ff[i] + 16'h0001;
    end
  end
endmodule // gpb_led_load

//--- tb/tb_top.sv
`timescale 1ns/100ps
module tb_top import gpb_pkg::*;;
  localparam int BLK = 50;
  localparam int TK = 4;
  localparam int FR = 100 * TK;
  logic mclk = 0, resetn = 0, cmd_valid = 0, en = 0;
  gpb_req_t cmd = '0;
  wire logic [3:0] p;
  wire logic rej;
  logic [15:0] c [4];
  int failures = 0, n_compared = 0, cyc = 0;
  initial forever #25 mclk = ~mclk;
  gpb_port #(.BLINK_CYC(BLK), .PWM_TICK_CYC(TK)) i_dut (.mclk(mclk), .resetn(resetn),
    .cmd_valid(cmd_valid), .cmd(cmd), .out_pin_zero(p[0]), .out_pin_one(p[1]),
    .out_pin_two(p[2]), .out_pin_three(p[3]), .cmd_reject_ff(rej));
  gpb_led_load i_load (.mclk(mclk), .pins(p), .count_en(en), .on_cnt_ff(c));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Reject flag compare
  task automatic chk_flag(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t flag got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Lit-cycle count compare
  task automatic chk_cnt(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t count got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic snd(input gpb_cmd_t op, input logic [7:0] pt, pn, input logic [31:0] v);
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd = '{op, pt, pn, v};
    @(negedge mclk);
    cmd_valid = 1'b0;
    repeat (5) @(negedge mclk);
  endtask
  // Whole frames only, so the count does not depend on phase
  task automatic meas(input int n);
    en = 1'b1;
    repeat (n) @(negedge mclk);
    en = 1'b0;
  endtask
  task automatic t_plain;
    chk(p, 32'h0);
    snd(GPB_CMD_WRITE_PORT, 8'h00, 8'h00, 32'h0000000F); chk(p, 32'hF);
    snd(GPB_CMD_WRITE_PORT, 8'h00, 8'h00, 32'h0000000A); chk(p, 32'hA);
    snd(GPB_CMD_WRITE_PIN, 8'h00, 8'h02, 32'h00000001); chk(p, 32'hE);
    snd(GPB_CMD_WRITE_PIN, 8'h00, 8'h05, 32'h00000000); chk_flag(rej, 1'b1);
    snd(GPB_CMD_WRITE_PIN, 8'h01, 8'h01, 32'h00000000); chk(p, 32'hE);
    snd(GPB_CMD_WRITE_PORT, 8'h00, 8'h00, 32'h00000000); chk(p, 32'h0);
    $display("plain test done");
  endtask
  task automatic t_pol;
    snd(GPB_CMD_POLARITY, 8'h00, 8'h00, 32'h00000000); chk(p, 32'h1);
    snd(GPB_CMD_POLARITY, 8'h00, 8'h00, 32'h00000001); chk(p, 32'h0);
    $display("polarity test done");
  endtask
  task automatic t_pwm;
    snd(GPB_CMD_DUTY, 8'h00, 8'h01, 32'h00000019);
    snd(GPB_CMD_DUTY, 8'h00, 8'h02, 32'h00000001);
    snd(GPB_CMD_DUTY, 8'h00, 8'h03, 32'h00000064);
    meas(FR);
    chk_cnt(c[1], 16'(FR / 4));
    chk_cnt(c[2], 16'(TK));
    chk_cnt(c[3], 16'(FR));
    // A duty above 100 must clamp to fully on, never wrap to a short pulse
    snd(GPB_CMD_DUTY, 8'h00, 8'h02, 32'h000000C8);
    meas(FR);
    chk_cnt(c[2], 16'(FR));
    $display("duty test done");
  endtask
  task automatic t_blink;
    snd(GPB_CMD_BLINK, 8'h00, 8'h00, 32'h000000FF);
    snd(GPB_CMD_DUTY, 8'h00, 8'h00, 32'h00000032);
    snd(GPB_CMD_DUTY, 8'h00, 8'h01, 32'h00000000);
    snd(GPB_CMD_WRITE_PIN, 8'h00, 8'h01, 32'h00000001);
    snd(GPB_CMD_BLINK, 8'h00, 8'h01, 32'h0000000F);
    meas(32 * BLK);
    chk_cnt(c[0], 16'(4 * BLK));
    chk_cnt(c[1], 16'(4 * BLK));
    $display("blink test done");
  endtask
  task automatic finish_test;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      finish_test();
    end
  end
  initial begin
    repeat (6) @(negedge mclk);
    resetn = 1'b1;
    t_plain();
    t_pol();
    t_pwm();
    t_blink();
    finish_test();
  end
endmodule // tb_top
bind gpb_port gpb_port_asserts i_chk (.mclk(mclk), .resetn(resetn), .cmd_valid(cmd_valid),
  .cmd(cmd), .out_pin_zero(out_pin_zero), .out_pin_one(out_pin_one),
  .out_pin_two(out_pin_two), .out_pin_three(out_pin_three), .cmd_reject_ff(cmd_reject_ff));
